// ### verilog/trap_vec_pkg.sv
// Overview of operation
// RULE1 - Every hardware trap is non-maskable and redirects execution at once to its own vector; the code sends all class B traps to the shared 0x28.
// RULE2 - Each hardware trap condition sets its own bit in the trap flag register.
// RULE3 - A hardware trap preempts any program unless a higher priority trap service is running; the code pends an equal class B, drops an equal class A.
// RULE4 - While a hardware trap service runs, standard interrupts and transfer requests are held.
// RULE5 - Hardware, software and watchdog reset all start at vector zero, trap zero, with no flag.
// RULE6 - Class A traps vector to 0x08 (trap 2), 0x10 (trap 4) and 0x18 (trap 6).
// RULE7 - All class B traps share the vector 0x28 and are told apart only by their flags.
// RULE8 - Class B traps exist for undefined opcode, protected fault, bad operand, fetch and bus.
// RULE9 - An external access not covered by any bus window raises the bad bus class B trap.
// RULE10 - A software trap takes any number 0x00 to 0x7f, vectors to four times it, keeps priority.
// RULE11 - Each node has request and enable flags and a vector at four times its trap number.
// RULE12 - The two-wire data event vectors to 0x100 (trap 0x40), protocol event to 0x104 (0x41).
// RULE13 - Each node can be given any of sixteen priority levels by software.
// RULE14 - An accepted service is interrupted only by a request of strictly higher priority.
// RULE15 - A request flag set by software acts as a genuine request from that node.
// RULE16 - A node requests only while request and enable are set; the flag clears when taken.
package trap_vec_pkg;
   localparam int NODE_COUNT = 27;
   localparam int NODE_W = 5;
   localparam int ADDR_W = 24;

   typedef enum logic [2:0] {
      kind_none,
      kind_reset,
      kind_class_a,
      kind_class_b,
      kind_soft,
      kind_node
   } branch_kind_t;

   typedef struct packed {
      logic [ADDR_W-1:0] vector_addr;
      logic [6:0] trap_number;
      branch_kind_t kind;
      logic [3:0] level;
      logic keep_level;
   } branch_t;

   // Trap flag register layout
   localparam int NMI_BIT = 15;
   localparam int STACK_OVER_BIT = 14;
   localparam int STACK_UNDER_BIT = 13;
   localparam int UNDEF_OPC_BIT = 7;
   localparam int PROT_FAULT_BIT = 3;
   localparam int BAD_OPERAND_BIT = 2;
   localparam int BAD_FETCH_BIT = 1;
   localparam int BAD_BUS_BIT = 0;
   localparam logic [15:0] TRAP_FLAG_RESET = 16'h0000;

   localparam logic [6:0] TRAP_RESET = 7'h00;
   localparam logic [6:0] TRAP_NMI = 7'h02;
   localparam logic [6:0] TRAP_STACK_OVER = 7'h04;
   localparam logic [6:0] TRAP_STACK_UNDER = 7'h06;
   localparam logic [6:0] TRAP_CLASS_B = 7'h0a;
   localparam logic [6:0] TRAP_SOFT_MAX = 7'h7f;
   localparam logic [ADDR_W-1:0] SOFT_VEC_MAX = 24'h0001fc;

   // Hardware trap priorities (class A above class B)
   localparam logic [1:0] PRIO_NONE = 2'h0;
   localparam logic [1:0] PRIO_CLASS_B = 2'h1;
   localparam logic [1:0] PRIO_CLASS_A = 2'h2;

   // Node trap numbers; node 0..7 external, 23 data, 24 protocol
   localparam logic [7*NODE_COUNT-1:0] NODE_TRAPS = {
      7'h43, 7'h42, 7'h41, 7'h40, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2b, 7'h47,
      7'h2a, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25, 7'h24, 7'h23, 7'h22,
      7'h1f, 7'h1e, 7'h1d, 7'h1c, 7'h1b, 7'h1a, 7'h19, 7'h18};
   localparam int NODE_EXT_IRQ0 = 0;
   localparam int NODE_TWOWIRE_DATA = 23;
   localparam int NODE_TWOWIRE_PROTOCOL = 24;

   // Register port offsets
   localparam logic [7:0] OFS_TRAP_FLAG = 8'h00;
   localparam logic [7:0] OFS_REQ = 8'h01;
   localparam logic [7:0] OFS_ENA = 8'h02;
   localparam logic [7:0] OFS_LEVEL_BASE = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h03;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFS_STATE = 8'h05;
   // Nodes 16 and up live in a second request and enable word
   localparam logic [7:0] OFS_REQ_HI = 8'h06;
   localparam logic [7:0] OFS_ENA_HI = 8'h07;

   function automatic logic [ADDR_W-1:0] vec_of(input logic [6:0] trap);
      vec_of = {15'h0000, trap, 2'b00};
   endfunction : vec_of
endpackage : trap_vec_pkg

// ### verilog/interrupt_trap_vectoring.sv
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module interrupt_trap_vectoring import trap_vec_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sw_reset,
   input wire logic wdt_overflow,
   input wire logic nmi_event,
   input wire logic stack_over_event,
   input wire logic stack_under_event,
   input wire logic undef_opcode_event,
   input wire logic prot_fault_event,
   input wire logic bad_operand_event,
   input wire logic bad_fetch_event,
   input wire logic ext_access,
   input wire logic ext_window_hit,
   input wire logic soft_trap,
   input wire logic [6:0] soft_trap_number,
   input wire logic [NODE_COUNT-1:0] node_event,
   input wire logic [3:0] cpu_level,
   input wire logic trap_return,
   input wire logic branch_ack,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   output logic branch_req,
   output branch_t branch,
   output logic transfer_block,
   output logic irq
);
   logic [15:0] trap_flag_reg_q;
   logic [NODE_COUNT-1:0] node_request_flag_q;
   logic [NODE_COUNT-1:0] node_enable_q;
   logic [3:0] node_level_q [NODE_COUNT];
   logic [1:0] trap_active_q;
   logic [1:0] irq_status_q;
   logic [1:0] irq_mask_q;
   logic branch_req_q;
   branch_t branch_q;
   logic [15:0] trap_set;
   logic [NODE_COUNT-1:0] req_nxt;
   logic class_b_pend_q;
   logic class_b_go;
   logic bad_bus;
   logic class_a_hit;
   logic class_b_hit;
   logic node_pick;
   logic [NODE_W-1:0] node_idx;
   logic [3:0] node_best;
   logic reset_hit;
   logic reg_hit_level;
   logic [7:0] level_ofs;

   assign bad_bus = ext_access & ~ext_window_hit; // see RULE9
   always_comb begin
      trap_set = 16'h0000;
      trap_set[NMI_BIT] = nmi_event; // see RULE2
      trap_set[STACK_OVER_BIT] = stack_over_event;
      trap_set[STACK_UNDER_BIT] = stack_under_event;
      trap_set[UNDEF_OPC_BIT] = undef_opcode_event; // see RULE8
      trap_set[PROT_FAULT_BIT] = prot_fault_event;
      trap_set[BAD_OPERAND_BIT] = bad_operand_event;
      trap_set[BAD_FETCH_BIT] = bad_fetch_event;
      trap_set[BAD_BUS_BIT] = bad_bus;
   end
   assign reset_hit = sw_reset | wdt_overflow;
   assign class_a_hit = (|trap_set[15:13]) & (trap_active_q < PRIO_CLASS_A); // see RULE3
   assign class_b_hit = (|trap_set[7:0] | class_b_pend_q) & (trap_active_q < PRIO_CLASS_B); // see RULE3
   assign class_b_go = class_b_hit & ~reset_hit & ~class_a_hit;

   // A class B trap held off by a running service is kept until it can be taken
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         class_b_pend_q <= 1'b0;
      end else if (reset_hit || class_b_go) begin
         class_b_pend_q <= 1'b0;
      end else if (|trap_set[7:0]) begin
         class_b_pend_q <= 1'b1; // see RULE1
      end
   end

   // Highest priority pending enabled node; ties go to the lower index
   always_comb begin
      node_pick = 1'b0;
      node_idx = '0;
      node_best = 4'h0;
      for (int i = 0; i < NODE_COUNT; i++) begin
         if (node_request_flag_q[i] && node_enable_q[i] && // see RULE16
             (!node_pick || node_level_q[i] > node_best)) begin
            node_pick = 1'b1;
            node_idx = NODE_W'(i);
            node_best = node_level_q[i];
         end
      end
      if (node_best <= cpu_level) begin // see RULE14
         node_pick = 1'b0;
      end
   end

   assign level_ofs = reg_addr - OFS_LEVEL_BASE;
   assign reg_hit_level = (reg_addr >= OFS_LEVEL_BASE) &&
                          (level_ofs < 8'(NODE_COUNT));

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         trap_flag_reg_q <= TRAP_FLAG_RESET;
      end else begin
         if (reg_write && reg_addr == OFS_TRAP_FLAG) begin
            trap_flag_reg_q <= (trap_flag_reg_q & reg_wdata) | trap_set; // see RULE2
         end else begin
            trap_flag_reg_q <= trap_flag_reg_q | trap_set;
         end
      end
   end

   // Request flags: hardware or software set wins over the taken clear
   always_comb begin
      req_nxt = node_request_flag_q;
      if (branch_ack && branch_q.kind == kind_node) begin
         for (int i = 0; i < NODE_COUNT; i++) begin
            if (NODE_TRAPS[7*i +: 7] == branch_q.trap_number) begin
               req_nxt[i] = 1'b0; // see RULE16
            end
         end
      end
      if (reg_write && reg_addr == OFS_REQ) begin
         req_nxt = (reg_wdata == 16'h0000) ? '0 : req_nxt | NODE_COUNT'(reg_wdata); // see RULE15
      end else if (reg_write && reg_addr == OFS_REQ_HI) begin
         req_nxt[NODE_COUNT-1:16] = req_nxt[NODE_COUNT-1:16] | reg_wdata[NODE_COUNT-17:0];
      end
      req_nxt = req_nxt | node_event;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         node_request_flag_q <= '0;
      end else begin
         node_request_flag_q <= req_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         node_enable_q <= '0;
      end else if (reg_write && reg_addr == OFS_ENA) begin
         node_enable_q[15:0] <= reg_wdata;
      end else if (reg_write && reg_addr == OFS_ENA_HI) begin
         node_enable_q[NODE_COUNT-1:16] <= reg_wdata[NODE_COUNT-17:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NODE_COUNT; i++) node_level_q[i] <= 4'h0;
      end else if (reg_write && reg_hit_level) begin
         node_level_q[level_ofs[NODE_W-1:0]] <= reg_wdata[3:0]; // see RULE13
      end
   end

   // Running hardware trap service level
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         trap_active_q <= PRIO_NONE;
      end else if (reset_hit) begin
         trap_active_q <= PRIO_NONE;
      end else if (class_a_hit) begin
         trap_active_q <= PRIO_CLASS_A;
      end else if (class_b_hit) begin
         trap_active_q <= PRIO_CLASS_B;
      end else if (trap_return) begin
         trap_active_q <= PRIO_NONE;
      end
   end
   assign transfer_block = trap_active_q != PRIO_NONE; // see RULE4

   // Branch request held until the pipeline acknowledges it
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         branch_req_q <= 1'b1;
         branch_q <= '{vector_addr: '0, trap_number: TRAP_RESET, kind: kind_reset,
                      level: 4'h0, keep_level: 1'b0};
      end else if (reset_hit) begin
         branch_req_q <= 1'b1; // see RULE5
         branch_q <= '{vector_addr: vec_of(TRAP_RESET), trap_number: TRAP_RESET,
                      kind: kind_reset, level: 4'h0, keep_level: 1'b0};
      end else if (class_a_hit) begin
         branch_req_q <= 1'b1; // see RULE1
         branch_q.kind <= kind_class_a;
         branch_q.level <= 4'hf;
         branch_q.keep_level <= 1'b0;
         if (nmi_event) begin
            branch_q.trap_number <= TRAP_NMI; // see RULE6
            branch_q.vector_addr <= vec_of(TRAP_NMI);
         end else if (stack_over_event) begin
            branch_q.trap_number <= TRAP_STACK_OVER;
            branch_q.vector_addr <= vec_of(TRAP_STACK_OVER);
         end else begin
            branch_q.trap_number <= TRAP_STACK_UNDER;
            branch_q.vector_addr <= vec_of(TRAP_STACK_UNDER);
         end
      end else if (class_b_hit) begin
         branch_req_q <= 1'b1;
         branch_q <= '{vector_addr: vec_of(TRAP_CLASS_B), trap_number: TRAP_CLASS_B,
                      kind: kind_class_b, level: 4'hf, keep_level: 1'b0}; // see RULE7
      end else if (branch_req_q) begin
         // No new pick at the taking edge: the taken node's flag is still set here
         branch_req_q <= !branch_ack;
         if (branch_ack) begin
            branch_q.kind <= kind_none;
         end
      end else if (soft_trap && trap_active_q == PRIO_NONE) begin
         branch_req_q <= 1'b1;
         branch_q <= '{vector_addr: vec_of(soft_trap_number & TRAP_SOFT_MAX),
                      trap_number: soft_trap_number, kind: kind_soft,
                      level: cpu_level, keep_level: 1'b1}; // see RULE10
      end else if (node_pick && trap_active_q == PRIO_NONE) begin // see RULE4
         branch_req_q <= 1'b1;
         branch_q <= '{vector_addr: vec_of(NODE_TRAPS[7*node_idx +: 7]), // see RULE11
                      trap_number: NODE_TRAPS[7*node_idx +: 7], kind: kind_node,
                      level: node_best, keep_level: 1'b0}; // see RULE12
      end else begin
         branch_req_q <= 1'b0;
         branch_q.kind <= kind_none;
      end
   end
   assign branch_req = branch_req_q;
   assign branch = branch_q;

   // Interrupt status: bit0 class A trap, bit1 class B trap
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_q <= 2'h0;
      end else begin
         irq_status_q <= (irq_status_q &
                         ~((reg_write && reg_addr == OFS_IRQ_STATUS) ? reg_wdata[1:0] : 2'h0))
                         | {|trap_set[7:0], |trap_set[15:13]};
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_q <= 2'h0;
      end else if (reg_write && reg_addr == OFS_IRQ_MASK) begin
         irq_mask_q <= reg_wdata[1:0];
      end
   end
   assign irq = |(irq_status_q & irq_mask_q);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         if (reg_addr == OFS_TRAP_FLAG) reg_rdata <= trap_flag_reg_q;
         else if (reg_addr == OFS_REQ) reg_rdata <= node_request_flag_q[15:0];
         else if (reg_addr == OFS_ENA) reg_rdata <= node_enable_q[15:0];
         else if (reg_addr == OFS_IRQ_STATUS) reg_rdata <= {14'h0000, irq_status_q};
         else if (reg_addr == OFS_IRQ_MASK) reg_rdata <= {14'h0000, irq_mask_q};
         else if (reg_addr == OFS_STATE) reg_rdata <= {14'h0000, trap_active_q};
         else if (reg_addr == OFS_REQ_HI) reg_rdata <= 16'(node_request_flag_q[NODE_COUNT-1:16]);
         else if (reg_addr == OFS_ENA_HI) reg_rdata <= 16'(node_enable_q[NODE_COUNT-1:16]);
         else if (reg_hit_level) reg_rdata <= {12'h000, node_level_q[level_ofs[NODE_W-1:0]]};
         else reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   property p_flag_set;
      @(posedge ref_clk) disable iff (!reset_n) nmi_event |=> trap_flag_reg_q[NMI_BIT];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("nmi flag not set"); // see RULE2
   property p_class_a_branch;
      @(posedge ref_clk) disable iff (!reset_n)
         (nmi_event && !reset_hit && trap_active_q != PRIO_CLASS_A) |=>
         (branch_req && branch.vector_addr == 24'h000008);
   endproperty
   a_class_a_branch: assert property (p_class_a_branch) else $error("nmi vector wrong"); // see RULE6
   property p_class_b_vec;
      @(posedge ref_clk) disable iff (!reset_n)
         (branch_req && branch.kind == kind_class_b) |-> branch.vector_addr == 24'h000028;
   endproperty
   a_class_b_vec: assert property (p_class_b_vec) else $error("class b vector wrong"); // see RULE7
   property p_reset_vec;
      @(posedge ref_clk) disable iff (!reset_n)
         sw_reset |=> (branch_req && branch.vector_addr == 24'h0 && $stable(trap_flag_reg_q));
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset branch wrong"); // see RULE5
   property p_block;
      @(posedge ref_clk) disable iff (!reset_n)
         (trap_active_q != PRIO_NONE && !branch_req) |=> branch.kind != kind_node;
   endproperty
   a_block: assert property (p_block) else $error("node taken during trap"); // see RULE4
   property p_soft;
      @(posedge ref_clk) disable iff (!reset_n)
         (branch_req && branch.kind == kind_soft) |->
         (branch.vector_addr <= SOFT_VEC_MAX && branch.keep_level &&
          branch.vector_addr == {15'h0000, branch.trap_number, 2'b00});
   endproperty
   a_soft: assert property (p_soft) else $error("soft trap vector wrong"); // see RULE10
   property p_node_level;
      @(posedge ref_clk) disable iff (!reset_n)
         (branch_req && !$past(branch_req) && branch.kind == kind_node) |->
         branch.level > $past(cpu_level);
   endproperty
   a_node_level: assert property (p_node_level) else $error("low level preempted"); // see RULE14
   property p_bad_bus;
      @(posedge ref_clk) disable iff (!reset_n)
         (ext_access && !ext_window_hit) |=> trap_flag_reg_q[BAD_BUS_BIT];
   endproperty
   a_bad_bus: assert property (p_bad_bus) else $error("bad bus flag missing"); // see RULE9
   c_class_a: cover property (@(posedge ref_clk) branch_req && branch.kind == kind_class_a);
   c_class_b: cover property (@(posedge ref_clk) branch_req && branch.kind == kind_class_b);
   c_node: cover property (@(posedge ref_clk) branch_req && branch.kind == kind_node);
   c_soft: cover property (@(posedge ref_clk) branch_req && branch.kind == kind_soft);
endmodule : interrupt_trap_vectoring

// ### bench/cpu_pipe_model.sv
`timescale 1ns/1ps
module cpu_pipe_model import trap_vec_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic branch_req,
   input wire branch_t branch,
   input wire logic [3:0] ack_delay,
   output logic branch_ack,
   output logic taken,
   output branch_t taken_branch
);
   logic [3:0] wait_q;

   // Stalls for ack_delay cycles, then takes whatever branch stands at the acknowledging edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_q <= '0;
         branch_ack <= 1'b0;
         taken <= 1'b0;
         taken_branch <= '0;
      end else begin
         taken <= branch_ack;
         if (branch_ack) begin
            branch_ack <= 1'b0;
            wait_q <= '0;
            taken_branch <= branch;
         end else if (branch_req && wait_q >= ack_delay) begin
            branch_ack <= 1'b1;
         end else if (branch_req) begin
            wait_q <= wait_q + 4'h1;
         end else begin
            wait_q <= '0;
         end
      end
   end
endmodule : cpu_pipe_model

// ### bench/interrupt_trap_vectoring_test.sv
`timescale 1ns/1ps
module interrupt_trap_vectoring_test;
   import trap_vec_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [12:0] ev_q = '0;
   logic ext_window_hit = 1'b0;
   logic [6:0] soft_trap_number = '0;
   logic [4:0] node_sel = '0;
   logic [3:0] cpu_level = '0;
   logic [3:0] ack_delay = '0;
   logic [7:0] reg_addr = '0;
   logic [15:0] reg_wdata = '0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic branch_req, branch_ack, transfer_block, irq, taken;
   logic [NODE_COUNT-1:0] node_event;
   branch_t branch, got;
   int mismatches = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'h15a4;

   always #2 ref_clk = ~ref_clk;
   assign node_event = ev_q[12] ? (27'h1 << node_sel) : '0;

   interrupt_trap_vectoring i_interrupt_trap_vectoring (.ref_clk(ref_clk), .reset_n(reset_n),
      .sw_reset(ev_q[0]), .wdt_overflow(ev_q[1]), .nmi_event(ev_q[2]),
      .stack_over_event(ev_q[3]), .stack_under_event(ev_q[4]), .undef_opcode_event(ev_q[5]),
      .prot_fault_event(ev_q[6]), .bad_operand_event(ev_q[7]), .bad_fetch_event(ev_q[8]),
      .ext_access(ev_q[9]), .ext_window_hit(ext_window_hit), .soft_trap(ev_q[10]),
      .soft_trap_number(soft_trap_number), .node_event(node_event), .cpu_level(cpu_level),
      .trap_return(ev_q[11]), .branch_ack(branch_ack), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .branch_req(branch_req), .branch(branch),
      .transfer_block(transfer_block), .irq(irq));

   cpu_pipe_model i_cpu_pipe_model (.ref_clk(ref_clk), .reset_n(reset_n),
      .branch_req(branch_req), .branch(branch), .ack_delay(ack_delay),
      .branch_ack(branch_ack), .taken(taken), .taken_branch(got));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction : xorshift

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      chk(what, 32'(exp), 32'(reg_rdata));
   endtask : rd

   task automatic pulse(input int k);
      @(posedge ref_clk);
      ev_q <= 13'(1 << k);
      @(posedge ref_clk);
      ev_q <= '0;
   endtask : pulse

   // Waits for the pipeline to take a branch, then compares what it took
   task automatic take(input logic [23:0] vec, input logic [6:0] tn, input branch_kind_t k);
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         #1;
         i++;
      end while (taken !== 1'b1 && i < 60);
      if (taken !== 1'b1) begin
         mismatches++;
         $display("[ERR] branch expected taken seen none");
         final_report();
      end else begin
         chk("vector", 32'(vec), 32'(got.vector_addr));
         chk("trap number", 32'(tn), 32'(got.trap_number));
         chk("kind", 32'(k), 32'(got.kind));
      end
   endtask : take

   task automatic no_branch(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (branch_req !== 1'b0)
            seen = 1'b1;
      end
      chk("no branch", 32'h0, 32'(seen));
   endtask : no_branch

   initial begin : main
      int i, n, lv;
      logic [4:0] bbit [5];
      bbit = '{5'd7, 5'd3, 5'd2, 5'd1, 5'd0};
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      take(24'h0, 7'h00, kind_reset);
      rd(OFS_TRAP_FLAG, 16'h0000, "flags after reset");
      for (i = 0; i < 2; i++) begin
         pulse(i);
         take(24'h0, 7'h00, kind_reset);
         rd(OFS_TRAP_FLAG, 16'h0000, "flags after reset function");
      end
      for (i = 0; i < 3; i++) begin
         seed = xorshift(seed);
         ack_delay <= seed[3:0];
         pulse(2 + i);
         take(24'(8 * (i + 1)), 7'(2 * (i + 1)), kind_class_a);
         chk("transfer_block", 32'h1, 32'(transfer_block));
         rd(OFS_TRAP_FLAG, 16'h8000 >> i, "class a flag");
         pulse(11);
         wr(OFS_TRAP_FLAG, 16'h0000);
      end
      ext_window_hit <= 1'b1;
      pulse(9);
      no_branch(6);
      ext_window_hit <= 1'b0;
      for (i = 0; i < 5; i++) begin
         pulse(i < 4 ? 5 + i : 9);
         take(24'h28, 7'h0a, kind_class_b);
         rd(OFS_TRAP_FLAG, 16'h1 << bbit[i], "class b flag");
         pulse(11);
         wr(OFS_TRAP_FLAG, 16'h0000);
      end
      ack_delay <= 4'h8;
      pulse(8);
      pulse(2);
      take(24'h08, 7'h02, kind_class_a);
      pulse(7);
      no_branch(6);
      rd(OFS_IRQ_STATUS, 16'h0003, "irq status");
      chk("irq masked", 32'h0, 32'(irq));
      wr(OFS_IRQ_MASK, 16'h0001);
      #1;
      chk("irq unmasked", 32'h1, 32'(irq));
      wr(OFS_IRQ_STATUS, 16'h0001);
      #1;
      chk("irq cleared", 32'h0, 32'(irq));
      wr(OFS_IRQ_MASK, 16'h0000);
      wr(OFS_IRQ_STATUS, 16'h0003);
      pulse(11);
      take(24'h28, 7'h0a, kind_class_b);
      pulse(11);
      wr(OFS_TRAP_FLAG, 16'h0000);
      for (i = 0; i < 8; i++) begin
         seed = xorshift(seed);
         n = (i == 0) ? 0 : (i == 1) ? 127 : (i == 2) ? 64 : int'(seed[6:0]);
         ack_delay <= seed[11:8];
         cpu_level <= seed[15:12];
         soft_trap_number <= 7'(n);
         pulse(10);
         take(24'(4 * n), 7'(n), kind_soft);
         chk("keep level", 32'h1, 32'(got.keep_level));
         chk("soft level", 32'(cpu_level), 32'(got.level));
      end
      for (i = 0; i < 6; i++) begin
         seed = xorshift(seed);
         n = int'(seed[2:0]);
         lv = (seed[7:4] == 4'h0) ? 1 : int'(seed[7:4]);
         ack_delay <= seed[11:8];
         node_sel <= 5'(n);
         cpu_level <= 4'(lv - 1);
         wr(8'(OFS_LEVEL_BASE + 8'(n)), 16'(lv));
         wr(OFS_ENA, 16'h1 << n);
         pulse(12);
         take(24'(4 * (24 + n)), 7'(24 + n), kind_node);
         chk("node level", 32'(lv), 32'(got.level));
         rd(OFS_REQ, 16'h0000, "request cleared");
         cpu_level <= 4'(lv);
         wr(OFS_REQ, 16'h1 << n);
         no_branch(6);
         cpu_level <= 4'(lv - 1);
         take(24'(4 * (24 + n)), 7'(24 + n), kind_node);
         wr(OFS_ENA, 16'h0000);
         wr(OFS_REQ, 16'h1 << n);
         no_branch(6);
         wr(OFS_REQ, 16'h0000);
      end
      wr(OFS_ENA, 16'h1 << n);
      pulse(2);
      take(24'h08, 7'h02, kind_class_a);
      pulse(12);
      no_branch(6);
      pulse(11);
      take(24'(4 * (24 + n)), 7'(24 + n), kind_node);
      chk("transfer_block", 32'h0, 32'(transfer_block));
      cpu_level <= 4'h0;
      for (i = 0; i < 2; i++) begin
         node_sel <= 5'(NODE_TWOWIRE_DATA + i);
         wr(8'(OFS_LEVEL_BASE + 8'(NODE_TWOWIRE_DATA + i)), 16'h0001);
         wr(OFS_ENA_HI, 16'h0080 << i);
         pulse(12);
         take(24'h000100 + 24'(4 * i), 7'h40 + 7'(i), kind_node);
      end
      rd(8'h0f, 16'h0000, "unmapped read");
      final_report();
   end
endmodule : interrupt_trap_vectoring_test
